/* File: inc/rah_pkg.sv */
// Constants shared by the access-hold and timeout block.
`default_nettype none
package rah_pkg;
    // System clock rate in MHz.
    localparam int unsigned RAH_CLK_MHZ         = 10;
    // Oscillator rate in Hz.
    localparam int unsigned RAH_OSC_HZ          = 32768;
    // Forced release delay after the first Start, in milliseconds.
    localparam int unsigned RAH_TIMEOUT_MS      = 500;
    // Forced release delay in oscillator edges.
    localparam int unsigned RAH_TIMEOUT_EDGES   = RAH_OSC_HZ * RAH_TIMEOUT_MS / 1000;
    // Longest wait from Stop to the deferred carry, in microseconds.
    localparam int unsigned RAH_CARRY_US        = 61;
    // Same wait in system clock cycles, ten per microsecond.
    localparam int unsigned RAH_CARRY_CYC       = RAH_CARRY_US * RAH_CLK_MHZ;
    // Last prescaler count of one second.
    localparam logic [14:0] RAH_PRESC_LAST      = 15'h7FFF;
    // Seven-bit bus address that the device answers.
    localparam logic [6:0]  RAH_SLAVE_ADDR      = 7'h32;
    // Register pointer value after every Stop.
    localparam logic [3:0]  RAH_PTR_STOP        = 4'hF;
    // Format bit that turns the access into a read after the pointer byte.
    localparam int unsigned RAH_FMT_READ_BIT    = 2;
    // Bits in one byte on the bus.
    localparam logic [3:0]  RAH_BYTE_BITS       = 4'h8;

    // Byte engine states, one-hot.
    typedef enum logic [4:0] {
        RAH_IDLE = 5'b00001,
        RAH_RECV = 5'b00010,
        RAH_ACK  = 5'b00100,
        RAH_SEND = 5'b01000,
        RAH_MACK = 5'b10000
    } rah_state_e;
endpackage
`default_nettype wire

/* File: inc/rah_sync_if.sv */
// Synchronised level and edge pulses of one outside signal.
`default_nettype none
interface rah_sync_if;
    logic level;  // Synchronised level.
    logic rise;   // One-cycle pulse on a rising edge.
    logic fall;   // One-cycle pulse on a falling edge.
    modport src (output level, output rise, output fall);
    modport dst (input level, input rise, input fall);
endinterface
`default_nettype wire

/* File: rtl/rah_sync.sv */
// Two-flop synchroniser with edge detection for one outside input.
`default_nettype none
module rah_sync (
    input  wire logic sys_clk,
    input  wire logic sys_rst,
    input  wire logic async_in,
    rah_sync_if.src   sig
);
    logic meta;   // First stage, read only by the second stage.
    logic stab;   // Second stage, safe to use.
    logic prev;   // Delayed copy for edge detection.

    // Idle level is high for both bus lines and harmless for the oscillator.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            meta <= 1'b1;
            stab <= 1'b1;
            prev <= 1'b1;
        end else begin
            meta <= async_in;
            stab <= meta;
            prev <= stab;
        end
    end

    // Edges are seen between the second and third stage only.
    assign sig.level = stab;
    assign sig.rise  = stab & ~prev;
    assign sig.fall  = ~stab & prev;
endmodule
`default_nettype wire

/* File: rtl/rah_top.sv */
// Bus access hold, deferred seconds carry and access timeout of the clock.
`default_nettype none
module rah_top
    import rah_pkg::*;
#(
    parameter int unsigned TIMEOUT_EDGES = RAH_TIMEOUT_EDGES,
    parameter logic [14:0] PRESC_LAST    = RAH_PRESC_LAST
) (
    input  wire logic       sys_clk,
    input  wire logic       sys_rst,
    input  wire logic       scl_pin,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    input  wire logic       osc_in,
    output logic            square_wave_out_pin,
    output logic [3:0]      reg_ptr,
    output logic            reg_wr_en,
    output logic [7:0]      reg_wr_data,
    input  wire logic [7:0] reg_rd_data,
    output logic            time_carry,
    output logic            time_frozen,
    output logic            timeout_fired
);
    rah_sync_if scl ();   // Bus clock, synchronised.
    rah_sync_if sda ();   // Bus data, synchronised.
    rah_sync_if osc ();   // Oscillator, synchronised.

    rah_sync u_scl (.sys_clk(sys_clk), .sys_rst(sys_rst), .async_in(scl_pin), .sig(scl));
    rah_sync u_sda (.sys_clk(sys_clk), .sys_rst(sys_rst), .async_in(sda_in),  .sig(sda));
    rah_sync u_osc (.sys_clk(sys_clk), .sys_rst(sys_rst), .async_in(osc_in),  .sig(osc));

    rah_state_e  state;       // Byte engine state.
    logic        in_access;   // Between first Start and Stop or forced release.
    logic        locked;      // Forced release has fired; stay silent.
    logic        pending;     // Seconds carry waiting for the freeze to end.
    logic [14:0] presc;       // Oscillator edges within the current second.
    logic [14:0] to_cnt;      // Oscillator edges since the first Start.
    logic [7:0]  shreg;       // Byte shift register.
    logic [3:0]  bitcnt;      // Bits taken or given in the current byte.
    logic [1:0]  byte_idx;    // 0 address, 1 pointer, 2 data and later.
    logic        rw_read;     // Direction bit of the address byte.
    logic [3:0]  fmt;         // Transmission format nibble.
    logic        more;        // Master acknowledged the last read byte.

    // Bus conditions while the clock line is high, plus the forced release and the second tick.
    logic start_cond;
    logic stop_cond;
    logic forced;
    logic end_access;
    logic sec_due;
    assign start_cond = scl.level & sda.fall;
    assign stop_cond  = scl.level & sda.rise;
    assign forced     = in_access & osc.rise & (to_cnt == 15'(TIMEOUT_EDGES - 1));
    assign end_access = stop_cond | forced;
    assign sec_due    = osc.rise & (presc == PRESC_LAST);

    // The square-wave pin copies the oscillator, untouched by any adjustment.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            square_wave_out_pin <= 1'b0;
        end else begin
            square_wave_out_pin <= osc.level;
        end
    end

    // Access window and its watchdog, timed from the first Start only.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            in_access <= 1'b0;
            to_cnt    <= 15'h0000;
        end else if (end_access) begin
            in_access <= 1'b0;
            to_cnt    <= 15'h0000;
        end else if (start_cond && !in_access) begin
            in_access <= 1'b1;
            to_cnt    <= 15'h0000;
        end else if (in_access && osc.rise) begin
            to_cnt    <= to_cnt + 15'h0001;
        end
    end

    // Silence after a forced release until the master sends a real Stop.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            locked <= 1'b0;
        end else if (forced) begin
            locked <= 1'b1;
        end else if (stop_cond) begin
            locked <= 1'b0;
        end
    end

    // Seconds prescaler and the carry held back while frozen.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            presc      <= 15'h0000;
            pending    <= 1'b0;
            time_carry <= 1'b0;
        end else begin
            // The prescaler wraps on the second tick, so a short second also works.
            if (sec_due) begin
                presc <= 15'h0000;
            end else if (osc.rise) begin
                presc <= presc + 15'h0001;
            end
            if (in_access || start_cond) begin
                pending    <= pending | sec_due;
                time_carry <= 1'b0;
            end else begin
                pending    <= 1'b0;
                time_carry <= pending | sec_due;
            end
        end
    end

    // Status outputs registered for the time counters.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            time_frozen   <= 1'b0;
            timeout_fired <= 1'b0;
        end else begin
            time_frozen   <= in_access | start_cond;
            timeout_fired <= locked | forced;
        end
    end

    // Byte engine: receive, acknowledge, send and pointer handling.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state       <= RAH_IDLE;
            shreg       <= 8'h00;
            bitcnt      <= 4'h0;
            byte_idx    <= 2'h0;
            rw_read     <= 1'b0;
            fmt         <= 4'h0;
            more        <= 1'b0;
            reg_ptr     <= RAH_PTR_STOP;
            reg_wr_en   <= 1'b0;
            reg_wr_data <= 8'h00;
            sda_out     <= 1'b0;
            sda_oe      <= 1'b0;
        end else begin
            reg_wr_en <= 1'b0;
            sda_out   <= 1'b0;
            if (end_access) begin
                // Real or forced Stop: release the line and park the pointer.
                state   <= RAH_IDLE;
                sda_oe  <= 1'b0;
                reg_ptr <= RAH_PTR_STOP;
            end else if (start_cond) begin
                // Start or repeated Start: expect an address byte.
                state    <= RAH_RECV;
                sda_oe   <= 1'b0;
                bitcnt   <= 4'h0;
                byte_idx <= 2'h0;
            end else begin
                case (state)
                    RAH_RECV: begin
                        if (scl.rise) begin
                            shreg  <= {shreg[6:0], sda.level};
                            bitcnt <= bitcnt + 4'h1;
                        end else if (scl.fall && bitcnt == RAH_BYTE_BITS) begin
                            if (byte_idx == 2'h0) begin
                                // Only the own address is acknowledged, never while silent.
                                if (shreg[7:1] == RAH_SLAVE_ADDR && !locked) begin
                                    state   <= RAH_ACK;
                                    sda_oe  <= 1'b1;
                                    rw_read <= shreg[0];
                                end else begin
                                    state <= RAH_IDLE;
                                end
                            end else if (byte_idx == 2'h1) begin
                                // Pointer and format nibble.
                                reg_ptr <= shreg[7:4];
                                fmt     <= shreg[3:0];
                                state   <= RAH_ACK;
                                sda_oe  <= 1'b1;
                            end else begin
                                // Data byte to the addressed register; the pointer moves after the strobe.
                                reg_wr_en   <= 1'b1;
                                reg_wr_data <= shreg;
                                state       <= RAH_ACK;
                                sda_oe      <= 1'b1;
                            end
                            if (byte_idx != 2'h2) begin
                                byte_idx <= byte_idx + 2'h1;
                            end
                        end
                    end
                    RAH_ACK: begin
                        // Advance only once the write strobe has shown the old pointer.
                        if (reg_wr_en) begin
                            reg_ptr <= reg_ptr + 4'h1;
                        end
                        if (scl.fall) begin
                            bitcnt <= 4'h0;
                            if (rw_read || (byte_idx == 2'h2 && fmt[RAH_FMT_READ_BIT])) begin
                                // Load the register byte and drive its first bit.
                                state   <= RAH_SEND;
                                shreg   <= reg_rd_data;
                                sda_oe  <= ~reg_rd_data[7];
                                reg_ptr <= reg_ptr + 4'h1;
                            end else begin
                                state  <= RAH_RECV;
                                sda_oe <= 1'b0;
                            end
                        end
                    end
                    RAH_SEND: begin
                        if (scl.rise) begin
                            bitcnt <= bitcnt + 4'h1;
                        end else if (scl.fall) begin
                            if (bitcnt == RAH_BYTE_BITS) begin
                                state  <= RAH_MACK;
                                sda_oe <= 1'b0;
                            end else begin
                                shreg  <= {shreg[6:0], 1'b0};
                                sda_oe <= ~shreg[6];
                            end
                        end
                    end
                    RAH_MACK: begin
                        if (scl.rise) begin
                            more <= ~sda.level;
                        end else if (scl.fall) begin
                            bitcnt <= 4'h0;
                            if (more) begin
                                state   <= RAH_SEND;
                                shreg   <= reg_rd_data;
                                sda_oe  <= ~reg_rd_data[7];
                                reg_ptr <= reg_ptr + 4'h1;
                            end else begin
                                state <= RAH_IDLE;
                            end
                        end
                    end
                    default: begin
                        state  <= RAH_IDLE;
                        sda_oe <= 1'b0;
                    end
                endcase
            end
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    // Stop with a held carry, followed by the carry pulse.
    sequence s_stop_with_pending;
        $fell(in_access) && pending;
    endsequence
    sequence s_carry_soon;
        ##[1:2] time_carry;
    endsequence

    a_freeze_no_carry: assert property (in_access |=> !time_carry)
        else $error("Carry reached time registers during an access.");
    a_carry_after_stop: assert property (s_stop_with_pending |-> s_carry_soon)
        else $error("Deferred carry not applied after Stop.");
    a_timeout_release: assert property (forced |=> !in_access && locked && state == RAH_IDLE)
        else $error("Timeout did not end the access.");
    a_restart_keeps_timer: assert property (in_access && start_cond && !forced |=> to_cnt >= $past(to_cnt))
        else $error("Repeated Start restarted the timeout.");
    a_locked_no_ack: assert property (locked |-> state != RAH_ACK && state != RAH_SEND)
        else $error("Device answered after forced release.");
    a_square_follows: assert property (osc.rise |=> square_wave_out_pin ##1 square_wave_out_pin)
        else $error("Square-wave pin does not follow oscillator.");
    a_addr_filter: assert property (state == RAH_RECV && byte_idx == 2'h0 && scl.fall && bitcnt == RAH_BYTE_BITS
        && shreg[7:1] != RAH_SLAVE_ADDR && !end_access |=> state == RAH_IDLE && !sda_oe)
        else $error("Foreign address was acknowledged.");
    a_stop_pointer: assert property (end_access |=> reg_ptr == RAH_PTR_STOP)
        else $error("Pointer not parked on Stop.");
    a_timer_bound: assert property (to_cnt <= 15'(TIMEOUT_EDGES - 1))
        else $error("Timeout counter ran past its limit.");
endmodule
`default_nettype wire

/* File: verif/rah_master.sv */
// Behavioural two-wire bus master that drives the block's bus pins.
`default_nettype none
module rah_master (
    input  wire logic sys_clk,
    input  wire logic sda_line,
    output var logic  scl,
    output var logic  sda_drv
);
    timeunit 1ns;
    timeprecision 1ns;
    // Both lines rest high, so the bus clock stands still between frames.
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    // Waits a number of system clock edges.
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // Start or repeated Start: data falls while the clock is high.
    task automatic start();
        sda_drv <= 1'b1;
        cyc(2);
        scl <= 1'b1;
        cyc(4);
        sda_drv <= 1'b0;
        cyc(4);
        scl <= 1'b0;
        cyc(2);
    endtask
    // One bit period of 800 ns; the line is sampled in mid-high.
    task automatic put_bit(input logic b, output logic seen);
        sda_drv <= b;
        cyc(2);
        scl <= 1'b1;
        cyc(2);
        seen = sda_line;
        cyc(2);
        scl <= 1'b0;
        cyc(2);
    endtask
    // Sends a byte MSB first and reports whether it was acknowledged.
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) put_bit(b[i], s);
        put_bit(1'b1, s);
        ack = (s === 1'b0);
    endtask
    // Receives a byte with the line released, then acks or refuses it.
    task automatic recv_byte(input logic nack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) put_bit(1'b1, b[i]);
        put_bit(nack, s);
    endtask
    // Stop condition, then a pause before any further Start is allowed.
    task automatic stop();
        sda_drv <= 1'b0;
        cyc(2);
        scl <= 1'b1;
        cyc(4);
        sda_drv <= 1'b1;
        cyc(620);
    endtask
endmodule
`default_nettype wire

/* File: verif/tb_top.sv */
// Self-checking bench for the access-hold and timeout block.
`default_nettype none
module tb_top
    import rah_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int unsigned TE = 8;  // Shortened forced-release count in oscillator edges.
    localparam logic [14:0] PL = 15'h0003;  // Shortened second of four oscillator edges.
    logic       sys_clk;             // System clock.
    logic       sys_rst;             // Synchronous reset.
    logic       osc_src;             // Free-running oscillator source.
    logic       osc_in;              // Oscillator as handed to the block.
    logic       scl_pin;             // Bus clock from the master.
    logic       sda_drv;             // Master's data drive, high means released.
    logic       sda_line;            // Resolved open-drain data line.
    logic       sda_oe;              // Device pulls data low.
    logic       sda_out;             // Device data output, always low.
    logic       sqw;                 // Square-wave output.
    logic [3:0] reg_ptr;             // Register pointer.
    logic       reg_wr_en;           // Register write strobe.
    logic [7:0] reg_wr_data;         // Register write byte.
    logic [7:0] reg_rd_data;         // Register read byte.
    logic       time_carry;          // Seconds advance pulse.
    logic       time_frozen;         // Time held by an access.
    logic       timeout_fired;       // Forced release state.
    logic [3:0] wr_ptr [0:3];        // Pointers seen at recent writes.
    logic [7:0] wr_dat [0:3];        // Bytes seen at recent writes.
    int         wr_n;                // Writes seen so far.
    int         cyc_cnt;             // Cycle counter.
    int         num_errors;          // Mismatches.
    int         num_checks;          // Comparisons.
    int         carry_n = 0;         // Carry pulses seen so far.
    // The line sits at its pull-up unless either party pulls it low.
    assign sda_line = sda_drv & ~sda_oe;
    rah_master m (.sys_clk(sys_clk), .sda_line(sda_line), .scl(scl_pin), .sda_drv(sda_drv));
    rah_top #(.TIMEOUT_EDGES(TE), .PRESC_LAST(PL)) uut (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .scl_pin(scl_pin), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe), .osc_in(osc_in), .square_wave_out_pin(sqw),
        .reg_ptr(reg_ptr), .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
        .reg_rd_data(reg_rd_data), .time_carry(time_carry), .time_frozen(time_frozen),
        .timeout_fired(timeout_fired)
    );
    // Clocks: 100 ns system period and a 32.768 kHz oscillator.
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    initial begin
        osc_src = 1'b0;
        forever #15259 osc_src = ~osc_src;
    end
    // Register file stand-in, write log and a watch on carries while frozen.
    always @(posedge sys_clk) begin
        osc_in <= osc_src;
        reg_rd_data <= {4'hA, reg_ptr};
        cyc_cnt <= cyc_cnt + 1;
        if (reg_wr_en === 1'b1) begin
            wr_ptr[wr_n % 4] <= reg_ptr;
            wr_dat[wr_n % 4] <= reg_wr_data;
            wr_n <= wr_n + 1;
        end
        if (time_carry === 1'b1) carry_n <= carry_n + 1;
        if (time_frozen === 1'b1) check(8'(time_carry), 8'h00);
        if (sys_rst === 1'b0) check(8'(sda_out), 8'h00);
    end
    // Compares one value and reports a mismatch at once.
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Prints the verdict and ends the run.
    task automatic conclude();
        if (num_errors == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Multi-byte write: ack, freeze, pointer order and pointer after Stop.
    task automatic t_write();
        logic a;
        int   n;
        n = wr_n;
        m.start();
        check(8'(time_frozen), 8'h01);
        m.send_byte({RAH_SLAVE_ADDR, 1'b0}, a);
        check(8'(a), 8'h01);
        m.send_byte(8'hE0, a);
        m.send_byte(8'h5A, a);
        m.send_byte(8'h3C, a);
        check(8'(time_frozen), 8'h01);
        m.stop();
        check(8'(reg_ptr), 8'h0F);
        check(8'(time_frozen), 8'h00);
        check(8'(wr_n - n), 8'h02);
        check({wr_ptr[n % 4], wr_ptr[(n + 1) % 4]}, 8'hEF);
        check(wr_dat[n % 4], 8'h5A);
        check(wr_dat[(n + 1) % 4], 8'h3C);
    endtask
    // A foreign address is never acknowledged.
    task automatic t_foreign();
        logic a;
        m.start();
        m.send_byte({7'h33, 1'b0}, a);
        check(8'(a), 8'h00);
        m.stop();
    endtask
    // Read after the format byte, then a bare read from the Stop pointer.
    task automatic t_read();
        logic       a;
        logic [7:0] d;
        m.start();
        m.send_byte({RAH_SLAVE_ADDR, 1'b0}, a);
        m.send_byte(8'h24, a);
        m.recv_byte(1'b0, d);
        check(d, 8'hA2);
        m.recv_byte(1'b1, d);
        check(d, 8'hA3);
        m.stop();
        m.start();
        m.send_byte({RAH_SLAVE_ADDR, 1'b1}, a);
        check(8'(a), 8'h01);
        m.recv_byte(1'b1, d);
        check(d, 8'hAF);
        m.stop();
    endtask
    // Stalled access with a repeated Start, forced release, then the lock.
    task automatic t_timeout();
        logic       a;
        logic [7:0] d;
        int         t0;
        int         dt;
        m.start();
        t0 = cyc_cnt;
        m.send_byte({RAH_SLAVE_ADDR, 1'b0}, a);
        m.cyc(900);
        m.start();
        m.send_byte({RAH_SLAVE_ADDR, 1'b0}, a);
        for (int i = 0; i < 4000 && timeout_fired !== 1'b1; i++) m.cyc(1);
        dt = cyc_cnt - t0;
        m.cyc(2);
        check(8'(timeout_fired), 8'h01);
        check(8'(dt >= (TE - 1) * 305 - 4 && dt <= (TE + 1) * 306), 8'h01);
        check(8'(time_frozen), 8'h00);
        check(8'(reg_ptr), 8'h0F);
        m.start();
        m.send_byte({RAH_SLAVE_ADDR, 1'b0}, a);
        check(8'(a), 8'h00);
        m.start();
        m.send_byte({RAH_SLAVE_ADDR, 1'b1}, a);
        m.recv_byte(1'b1, d);
        check(d, 8'hFF);
        m.stop();
        check(8'(timeout_fired), 8'h00);
        m.start();
        m.send_byte({RAH_SLAVE_ADDR, 1'b0}, a);
        check(8'(a), 8'h01);
        m.stop();
    endtask
    // The square-wave pin follows both oscillator levels.
    task automatic t_sqw();
        repeat (3) begin
            @(posedge osc_src);
            m.cyc(6);
            check(8'(sqw), 8'h01);
            @(negedge osc_src);
            m.cyc(6);
            check(8'(sqw), 8'h00);
        end
    endtask
    // A second tick that falls inside an access is held, then applied right after Stop.
    task automatic t_carry();
        int c0;
        m.start();
        c0 = carry_n;
        m.cyc(1300);
        check(8'(carry_n - c0), 8'h00);
        m.stop();
        check(8'(carry_n - c0 >= 1 && carry_n - c0 <= 2), 8'h01);
    endtask
    // Main sequence.
    initial begin
        sys_rst = 1'b1;
        cyc_cnt = 0;
        wr_n = 0;
        num_errors = 0;
        num_checks = 0;
        m.cyc(2);
        sys_rst <= 1'b0;
        m.cyc(3);
        t_write();
        t_foreign();
        t_read();
        t_timeout();
        t_sqw();
        t_carry();
        conclude();
    end
    // Watchdog against a hung bus.
    initial begin
        repeat (30000) @(posedge sys_clk);
        num_errors++;
        conclude();
    end
endmodule
`default_nettype wire
